//--- dv/gsrp_master.sv
`timescale 1ns/1ns

module gsrp_master (
    // Serial link driven by the master
    output logic sclk,
    output logic ssb_n,
    output logic mosi,
    // Slave reply and its enable
    input wire logic miso,
    input wire logic miso_oe_n
);
    // Released line shows the inverse so a stale bit cannot pass by luck
    wire miso_w = miso_oe_n ? ~miso : miso;

    initial begin
        sclk = 1'b0;
        ssb_n = 1'b1;
        mosi = 1'b0;
    end

    // Clock stands low outside frames; argument length is given by the caller, not taken from the instruction
    task automatic xfer(input logic [7:0] op, input int nbits, output logic [63:0] rx);
        int i;
        rx = '0;
        #37;
        ssb_n = 1'b0;
        #240;
        for (i = 0; i < 8 + nbits; i++) begin
            mosi = (i < 8) ? op[7 - i] : 1'b0;
            #80;
            sclk = 1'b1;
            if (i >= 8) begin
                rx = {rx[62:0], miso_w};
            end
            #80;
            sclk = 1'b0;
        end
        #160;
        ssb_n = 1'b1;
        // Released data line must not keep its last value
        mosi = ~mosi;
        #400;
    endtask
endmodule

//--- dv/gsrp_top_bench.sv
`timescale 1ns/1ns

module gsrp_top_bench;
    logic clk, rstn, sample_valid, drive_stable, spin_sel, therm_sel;
    logic [23:0] rate_comp, rate_raw;
    logic [13:0] temp_raw, temp_cal;
    logic sclk, ssb_n, mosi, miso, miso_oe_n, pulse, nsf, health;
    logic [63:0] rx;
    int err_count = 0;
    int cmp_count = 0;

    gsrp_top dut (
        .CLK(clk), .RSTN(rstn),
        .RATE_COMP(rate_comp), .RATE_RAW(rate_raw),
        .TEMP_RAW(temp_raw), .TEMP_CAL(temp_cal),
        .SAMPLE_VALID(sample_valid), .DRIVE_STABLE(drive_stable),
        .SPIN_COMP_SELECT(spin_sel), .THERMAL_COMP_SELECT(therm_sel),
        .SCLK(sclk), .SSB_N(ssb_n), .MOSI(mosi),
        .MISO(miso), .MISO_OE_N(miso_oe_n),
        .NEW_SAMPLE_PULSE(pulse), .NEW_SAMPLE_FLAG(nsf), .HEALTH_FLAG(health)
    );

    gsrp_master mst (
        .sclk(sclk), .ssb_n(ssb_n), .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input bit ok, input string msg);
        cmp_count++;
        if (!ok) begin
            err_count++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Fresh sample: pulse for one cycle, flag held, health taken with it
    task automatic t_sample(input logic [23:0] comp, input logic [23:0] raw, input logic st);
        @(posedge clk);
        rate_comp <= comp;
        rate_raw <= raw;
        drive_stable <= st;
        sample_valid <= 1'b1;
        @(posedge clk);
        sample_valid <= 1'b0;
        #1;
        chk(pulse === 1'b1, "new sample pulse missing");
        chk(nsf === 1'b1, "new sample flag not set");
        chk(health === st, "health pin");
        @(posedge clk);
        #1;
        chk(pulse === 1'b0, "pulse longer than one cycle");
        repeat (5) @(posedge clk);
    endtask

    // Full rate read, then the flag must drop
    task automatic t_rate(input logic [23:0] exp_rate, input logic exp_h);
        mst.xfer(8'h50, 32, rx);
        chk(rx[31:8] === exp_rate, "rate word");
        chk(rx[7:6] === {1'b1, exp_h}, "flag bits in rate frame");
        chk(rx[5:0] === 6'h00, "unused rate bits");
        chk(miso_oe_n === 1'b1, "output not released");
        repeat (5) @(posedge clk);
        chk(nsf === 1'b0, "flag not cleared by read");
    endtask

    // Temperature word, uncalibrated then calibrated
    task automatic t_temp;
        logic sel;
        for (int k = 0; k < 2; k++) begin
            sel = k[0];
            @(posedge clk);
            therm_sel <= sel;
            temp_raw <= 14'h2a5c;
            temp_cal <= 14'h1357;
            repeat (4) @(posedge clk);
            mst.xfer(8'h54, 16, rx);
            chk(rx[15:0] === {2'b00, sel ? 14'h1357 : 14'h2a5c}, "temperature");
        end
    endtask

    // Advanced and unknown frames answer zeros; these and an aborted rate frame keep the flag
    task automatic t_adv;
        logic [7:0] ops [3];
        int lens [3];
        ops = '{8'h58, 8'h78, 8'h7c};
        lens = '{32, 64, 16};
        t_sample(24'h2dc6c0, 24'h000001, 1'b1);
        for (int k = 0; k < 3; k++) begin
            mst.xfer(ops[k], lens[k], rx);
            chk(rx === 64'h0, "advanced reply");
        end
        mst.xfer(8'h51, 32, rx);
        chk(rx === 64'h0, "refused instruction reply");
        mst.xfer(8'h50, 16, rx);
        repeat (5) @(posedge clk);
        chk(nsf === 1'b1, "flag cleared by other frames");
        t_rate(24'h2dc6c0, 1'b1);
    endtask

    initial begin
        #2000000;
        err_count++;
        test_done();
    end

    initial begin
        rstn = 1'b0;
        sample_valid = 1'b0;
        drive_stable = 1'b0;
        spin_sel = 1'b1;
        therm_sel = 1'b0;
        rate_comp = 24'h0;
        rate_raw = 24'h0;
        temp_raw = 14'h0;
        temp_cal = 14'h0;
        // Two edges load every system clock reset value, synchronisers included
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk(nsf === 1'b0 && health === 1'b0 && pulse === 1'b0, "reset state");
        chk(miso_oe_n === 1'b1, "idle output enabled");
        t_sample(24'hd23940, 24'h123456, 1'b1);
        t_rate(24'hd23940, 1'b1);
        @(posedge clk);
        spin_sel <= 1'b0;
        t_sample(24'h7fffff, 24'h800000, 1'b0);
        t_rate(24'h800000, 1'b0);
        @(posedge clk);
        spin_sel <= 1'b1;
        t_temp();
        t_adv();
        test_done();
    end
endmodule

//--- hdl/gsrp_decode.sv
`timescale 1ns/1ns
`include "gsrp_regs.svh"

module gsrp_decode
    import gsrp_pkg::*;
(
    // Received instruction byte
    input wire logic [7:0] opcode,
    // Command class and argument length in bits
    output gsrp_cmd_t kind,
    output logic [6:0] arg_bits
);

    always_comb begin
        case (opcode)
            `GSRP_OP_RATE: begin
                kind = GSRP_CMD_RATE;
                arg_bits = `GSRP_ARG4_BITS;
            end
            `GSRP_OP_TEMP: begin
                kind = GSRP_CMD_TEMP;
                arg_bits = `GSRP_ARG2_BITS;
            end
            `GSRP_OP_ADV4: begin
                kind = GSRP_CMD_ADV;
                arg_bits = `GSRP_ARG4_BITS;
            end
            `GSRP_OP_ADV8: begin
                kind = GSRP_CMD_ADV;
                arg_bits = `GSRP_ARG8_BITS;
            end
            `GSRP_OP_ADV2: begin
                kind = GSRP_CMD_ADV;
                arg_bits = `GSRP_ARG2_BITS;
            end
            default: begin
                kind = GSRP_CMD_NONE;
                arg_bits = 7'h00;
            end
        endcase
    end

endmodule

//--- hdl/gsrp_pkg.sv
package gsrp_pkg;

    typedef enum logic [1:0] {
        GSRP_CMD_NONE,
        GSRP_CMD_RATE,
        GSRP_CMD_TEMP,
        GSRP_CMD_ADV
    } gsrp_cmd_t;

    typedef enum logic [1:0] {
        GSRP_PH_INSTR,
        GSRP_PH_ARG,
        GSRP_PH_OVER
    } gsrp_phase_t;

endpackage

//--- hdl/gsrp_regs.svh
`ifndef GSRP_REGS_SVH
`define GSRP_REGS_SVH

// Instruction codes
`define GSRP_OP_RATE 8'h50
`define GSRP_OP_TEMP 8'h54
`define GSRP_OP_ADV4 8'h58
`define GSRP_OP_ADV8 8'h78
`define GSRP_OP_ADV2 8'h7c

// Frame lengths and last bit indices in serial clock bits
`define GSRP_INSTR_BITS 7'h08
`define GSRP_ARG2_BITS 7'h10
`define GSRP_ARG4_BITS 7'h20
`define GSRP_ARG8_BITS 7'h40
`define GSRP_CNT_MAX 7'h48
`define GSRP_RATE_LAST 7'h27
`define GSRP_ADV8_LAST 7'h47

// Rate frame field positions
`define GSRP_RATE_MSB 31
`define GSRP_RATE_LSB 8
`define GSRP_NSF_BIT 7
`define GSRP_HLT_BIT 6

// Temperature word width
`define GSRP_TEMP_W 14

// Reset values
`define GSRP_NSF_RST 1'b0
`define GSRP_HLT_RST 1'b0
`define GSRP_SSB_RST 1'b1

`endif

//--- hdl/gsrp_sync.sv
`timescale 1ns/1ns

module gsrp_sync #(
    parameter logic RST_VAL = 1'b0
)(
    // Destination clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Asynchronous level in, synchronised level out
    input wire logic d,
    output logic q
);

    logic meta;

    // First stage feeds the second stage only
    always_ff @(posedge clk) begin
        if (!rstn) begin
            meta <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta <= d;
            q <= meta;
        end
    end

endmodule

//--- hdl/gsrp_top.sv
`timescale 1ns/1ns
`include "gsrp_regs.svh"

// Overview of operation
// [R01] Serial slave in mode 0: sample on rising, change on falling clock.
// [R02] Serial output released to high impedance while select is high.
// [R03] Frame is one instruction byte then two, four or eight argument bytes.
// [R04] Code 0x50 returns rate frame, code 0x54 returns temperature frame.
// [R05] Codes 0x58, 0x78, 0x7C accepted as advanced; all others refused.
// [R06] Master extracts the 24-bit rate word from the 32-bit response.
// [R07] Rate frame carries new-sample and health flags matching the pins.
// [R08] Rate word is 24-bit two's complement.
// [R09] Compensated rate: one step equals 1/10000 degree per second.
// [R10] Compensated codes map linearly; -300 deg/s is 0xd23940.
// [R11] With compensation off the host must measure scale itself.
// [R12] New-sample flag set on fresh sample, held until that sample is read.
// [R13] Health flag updated at output data rate, one while drive is stable.
// [R14] Health check runs alongside measurement without stalling output.
// [R15] Health pin is high while the sensor works correctly.
// [R16] Temperature read returns 14-bit unsigned word in two bytes.
// [R17] Temperature output is uncalibrated unless thermal compensation is selected.
// [R18] Select is active low and frames each transaction.
// [R19] New-sample pin pulses once per fresh rate sample.
// [R20] Spin compensation select one gives calibrated rate, zero gives raw.
// [R21] Bytes travel most significant bit first; reply during argument bytes.
// [R22] A completed rate read clears the new-sample flag at frame end.

module gsrp_top
    import gsrp_pkg::*;
#(
    parameter int RATE_W = 24,
    parameter int TEMP_W = `GSRP_TEMP_W
)(
    // System clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // Sensor core samples
    input wire logic [RATE_W-1:0] RATE_COMP,
    input wire logic [RATE_W-1:0] RATE_RAW,
    input wire logic [TEMP_W-1:0] TEMP_RAW,
    input wire logic [TEMP_W-1:0] TEMP_CAL,
    input wire logic SAMPLE_VALID,
    input wire logic DRIVE_STABLE,
    // Configuration
    input wire logic SPIN_COMP_SELECT,
    input wire logic THERMAL_COMP_SELECT,
    // Serial link
    input wire logic SCLK,
    input wire logic SSB_N,
    input wire logic MOSI,
    output logic MISO,
    output logic MISO_OE_N,
    // Status pins
    output logic NEW_SAMPLE_PULSE,
    output logic NEW_SAMPLE_FLAG,
    output logic HEALTH_FLAG
);

    // System side
    logic ssb_s;
    logic ssb_d;
    logic frame_end;
    logic link_clr_n;
    logic tgl_s;
    logic tgl_d;
    logic rd_evt;
    logic rd_pend;
    logic new_sample_flag;
    logic health_flag;
    logic nsf_pulse;
    logic [RATE_W-1:0] rate_sel;
    logic [TEMP_W-1:0] temp_sel;
    logic [31:0] snap_rate;
    logic [15:0] snap_temp;

    // Link side
    logic [6:0] bit_cnt;
    logic [6:0] arg_last;
    logic [6:0] in_shift;
    logic [7:0] opcode;
    logic [31:0] out_shift;
    logic [31:0] reply;
    logic [6:0] dec_len;
    gsrp_cmd_t dec_kind;
    gsrp_cmd_t cmd;
    gsrp_phase_t phase;
    logic done_tgl;
    logic miso_q;
    logic instr_edge;
    logic rate_last_edge;

    gsrp_sync #(
        .RST_VAL(`GSRP_SSB_RST)
    ) u_ssb_sync (
        .clk(CLK),
        .rstn(RSTN),
        .d(SSB_N),
        .q(ssb_s)
    );

    gsrp_sync #(
        .RST_VAL(1'b0)
    ) u_tgl_sync (
        .clk(CLK),
        .rstn(RSTN),
        .d(done_tgl),
        .q(tgl_s)
    );

    gsrp_decode u_decode (
        .opcode(opcode),
        .kind(dec_kind),
        .arg_bits(dec_len)
    );

    assign frame_end = ssb_s & ~ssb_d;
    assign rd_evt = tgl_s ^ tgl_d;

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            ssb_d <= `GSRP_SSB_RST;
            tgl_d <= 1'b0;
            link_clr_n <= 1'b0;
        end else begin
            ssb_d <= ssb_s;
            tgl_d <= tgl_s;
            link_clr_n <= 1'b1;
        end
    end

    // Read completion waits for the frame to close before clearing the flag
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            rd_pend <= 1'b0;
        end else if (frame_end) begin
            rd_pend <= 1'b0; // see [R22]
        end else if (rd_evt) begin
            rd_pend <= 1'b1;
        end
    end

    // A sample landing on the clearing cycle keeps the flag up
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            new_sample_flag <= `GSRP_NSF_RST;
        end else if (SAMPLE_VALID) begin
            new_sample_flag <= 1'b1; // see [R12]
        end else if (frame_end && (rd_pend || rd_evt)) begin
            new_sample_flag <= 1'b0; // see [R22]
        end
    end

    // Independent of the serial path, so the stream never stalls
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            health_flag <= `GSRP_HLT_RST;
        end else if (SAMPLE_VALID) begin
            health_flag <= DRIVE_STABLE; // see [R13] see [R14]
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            nsf_pulse <= 1'b0;
        end else begin
            nsf_pulse <= SAMPLE_VALID; // see [R19]
        end
    end

    assign rate_sel = SPIN_COMP_SELECT ? RATE_COMP : RATE_RAW; // see [R09] see [R20]
    assign temp_sel = THERMAL_COMP_SELECT ? TEMP_CAL : TEMP_RAW; // see [R17]

    // Snapshot frozen while a frame runs; link reads it only after the
    // instruction byte, so SSB must fall some 400 ns before the 8th edge
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            snap_rate <= 32'h0000_0000;
        end else if (ssb_s) begin
            snap_rate <= {rate_sel, new_sample_flag, health_flag, // see [R07] see [R08]
                {(30-RATE_W){1'b0}}}; // see [R10]
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            snap_temp <= 16'h0000;
        end else if (ssb_s) begin
            snap_temp <= {{(16-TEMP_W){1'b0}}, temp_sel}; // see [R16]
        end
    end

    assign NEW_SAMPLE_PULSE = nsf_pulse;
    assign NEW_SAMPLE_FLAG = new_sample_flag;
    assign HEALTH_FLAG = health_flag; // see [R15]

    // Link domain: SSB high clears the frame state asynchronously
    assign opcode = {in_shift, MOSI};
    assign instr_edge = (phase == GSRP_PH_INSTR) && (bit_cnt == `GSRP_INSTR_BITS - 7'h01);
    assign rate_last_edge = (phase == GSRP_PH_ARG) && (cmd == GSRP_CMD_RATE) &&
        (bit_cnt == arg_last);

    always_comb begin
        case (dec_kind)
            GSRP_CMD_RATE: reply = snap_rate; // see [R04]
            GSRP_CMD_TEMP: reply = {snap_temp, 16'h0000}; // see [R04]
            default: reply = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge SCLK or posedge SSB_N) begin
        if (SSB_N) begin
            bit_cnt <= 7'h00; // see [R18]
        end else if (bit_cnt != `GSRP_CNT_MAX) begin
            bit_cnt <= bit_cnt + 7'h01;
        end
    end

    always_ff @(posedge SCLK or posedge SSB_N) begin
        if (SSB_N) begin
            in_shift <= 7'h00;
        end else begin
            in_shift <= opcode[6:0]; // see [R01] see [R21]
        end
    end

    always_ff @(posedge SCLK or posedge SSB_N) begin
        if (SSB_N) begin
            phase <= GSRP_PH_INSTR;
            cmd <= GSRP_CMD_NONE;
            arg_last <= 7'h00;
        end else begin
            case (phase)
                GSRP_PH_INSTR: begin
                    if (instr_edge) begin
                        cmd <= dec_kind; // see [R05]
                        arg_last <= `GSRP_INSTR_BITS + dec_len - 7'h01; // see [R03]
                        phase <= (dec_kind == GSRP_CMD_NONE) ? GSRP_PH_OVER : GSRP_PH_ARG;
                    end
                end
                GSRP_PH_ARG: begin
                    if (bit_cnt == arg_last) begin
                        phase <= GSRP_PH_OVER;
                    end
                end
                GSRP_PH_OVER: begin
                    phase <= GSRP_PH_OVER;
                end
                default: begin
                    phase <= GSRP_PH_OVER;
                end
            endcase
        end
    end

    // Reply shifted out MSB first; zeros outside the argument field
    always_ff @(posedge SCLK or posedge SSB_N) begin
        if (SSB_N) begin
            out_shift <= 32'h0000_0000;
        end else if (instr_edge) begin
            out_shift <= reply; // see [R21]
        end else if (phase == GSRP_PH_ARG && bit_cnt != arg_last) begin
            out_shift <= {out_shift[30:0], 1'b0};
        end else begin
            out_shift <= 32'h0000_0000;
        end
    end

    // Output changes on the falling edge, ahead of the master's sample
    always_ff @(negedge SCLK or posedge SSB_N) begin
        if (SSB_N) begin
            miso_q <= 1'b0;
        end else begin
            miso_q <= out_shift[31]; // see [R01]
        end
    end

    // Survives SSB so a finished read reaches the system side
    always_ff @(posedge SCLK or negedge link_clr_n) begin
        if (!link_clr_n) begin
            done_tgl <= 1'b0;
        end else if (rate_last_edge) begin
            done_tgl <= ~done_tgl; // see [R06] see [R22]
        end
    end

    assign MISO = miso_q;
    assign MISO_OE_N = SSB_N; // see [R02]

    AST_HEALTH_ODR: assert property ( // see [R13]
        @(posedge CLK) disable iff (!RSTN)
        SAMPLE_VALID |=> (HEALTH_FLAG == $past(DRIVE_STABLE))
    ) else $error("health flag not refreshed from drive state");

    AST_HEALTH_HOLD: assert property ( // see [R14]
        @(posedge CLK) disable iff (!RSTN)
        !SAMPLE_VALID |=> $stable(HEALTH_FLAG)
    ) else $error("health flag moved between samples");

    AST_NSF_SET: assert property ( // see [R12]
        @(posedge CLK) disable iff (!RSTN)
        SAMPLE_VALID |=> NEW_SAMPLE_FLAG [*1] ##0 (NEW_SAMPLE_PULSE)
    ) else $error("fresh sample did not raise flag and pulse");

    AST_NSF_CLEAR_CAUSE: assert property ( // see [R22]
        @(posedge CLK) disable iff (!RSTN)
        $fell(NEW_SAMPLE_FLAG) |-> $past(frame_end && (rd_pend || rd_evt) && !SAMPLE_VALID)
    ) else $error("new sample flag cleared without a completed rate read");

    AST_PULSE_FLAG: assert property ( // see [R19]
        @(posedge CLK) disable iff (!RSTN)
        NEW_SAMPLE_PULSE |-> NEW_SAMPLE_FLAG
    ) else $error("sample pulse without flag");

    AST_SNAP_FROZEN: assert property ( // see [R04]
        @(posedge CLK) disable iff (!RSTN)
        (!ssb_s && !$past(ssb_s)) |-> ($stable(snap_rate) && $stable(snap_temp))
    ) else $error("snapshot changed during a frame");

    AST_FRAME_FLAGS: assert property ( // see [R07]
        @(posedge CLK) disable iff (!RSTN)
        ssb_s |=> (snap_rate[`GSRP_NSF_BIT] == $past(NEW_SAMPLE_FLAG)) &&
            (snap_rate[`GSRP_HLT_BIT] == $past(HEALTH_FLAG))
    ) else $error("frame flags differ from pins");

    AST_RATE_SELECT: assert property ( // see [R20]
        @(posedge CLK) disable iff (!RSTN)
        ssb_s |=> (snap_rate[`GSRP_RATE_MSB:`GSRP_RATE_LSB] ==
            $past(SPIN_COMP_SELECT ? RATE_COMP : RATE_RAW))
    ) else $error("rate word does not follow compensation select");

    AST_TEMP_SELECT: assert property ( // see [R17]
        @(posedge CLK) disable iff (!RSTN)
        ssb_s |=> (snap_temp[15:TEMP_W] == '0) &&
            (snap_temp[TEMP_W-1:0] == $past(THERMAL_COMP_SELECT ? TEMP_CAL : TEMP_RAW))
    ) else $error("temperature word wrong");

    AST_INSTR_QUIET: assert property ( // see [R21]
        @(posedge SCLK) disable iff (SSB_N)
        (phase == GSRP_PH_INSTR) |-> (out_shift == 32'h0000_0000)
    ) else $error("output data during instruction byte");

    AST_RATE_DONE_AT_40: assert property ( // see [R03]
        @(posedge SCLK) disable iff (SSB_N)
        (done_tgl != $past(done_tgl)) |->
            ($past(cmd) == GSRP_CMD_RATE && $past(bit_cnt) == `GSRP_RATE_LAST)
    ) else $error("rate read completed at wrong bit");

    AST_ADV8_LEN: assert property ( // see [R05]
        @(posedge SCLK) disable iff (SSB_N)
        (instr_edge && opcode == `GSRP_OP_ADV8) |=>
            (phase == GSRP_PH_ARG && cmd == GSRP_CMD_ADV && arg_last == `GSRP_ADV8_LAST)
    ) else $error("eight byte advanced command length wrong");

    AST_UNAUTH_REFUSED: assert property ( // see [R05]
        @(posedge SCLK) disable iff (SSB_N)
        (instr_edge && dec_kind == GSRP_CMD_NONE) |=>
            (phase == GSRP_PH_OVER && out_shift == 32'h0000_0000)
    ) else $error("unknown instruction not refused");

    COV_RATE_READ: cover property (
        @(posedge CLK) disable iff (!RSTN)
        frame_end && rd_pend
    );

    COV_TEMP_READ: cover property (
        @(posedge SCLK) disable iff (SSB_N)
        phase == GSRP_PH_ARG && cmd == GSRP_CMD_TEMP && bit_cnt == arg_last
    );

    COV_ADV_CMD: cover property (
        @(posedge SCLK) disable iff (SSB_N)
        phase == GSRP_PH_ARG && cmd == GSRP_CMD_ADV
    );

    COV_SET_ON_CLEAR: cover property (
        @(posedge CLK) disable iff (!RSTN)
        SAMPLE_VALID && frame_end && rd_pend
    );

endmodule
